// ---- hdl/supervisor_watchdog_reset_params.svh ----
`ifndef SUPERVISOR_WATCHDOG_RESET_PARAMS_SVH
`define SUPERVISOR_WATCHDOG_RESET_PARAMS_SVH

// ****************************************************************
// Clock
// ****************************************************************
`define SWR_CLK_PERIOD_NS  100
`define SWR_CYC_PER_US     (1000 / `SWR_CLK_PERIOD_NS)

// ****************************************************************
// Reset hold options, minimum values in microseconds
// ****************************************************************
`define SWR_RST_HOLD_US_A  1000
`define SWR_RST_HOLD_US_B  20000
`define SWR_RST_HOLD_US_C  140000
`define SWR_RST_HOLD_US_D  1120000
`define SWR_RST_HOLD_CYC_A (`SWR_RST_HOLD_US_A * `SWR_CYC_PER_US)
`define SWR_RST_HOLD_CYC_B (`SWR_RST_HOLD_US_B * `SWR_CYC_PER_US)
`define SWR_RST_HOLD_CYC_C (`SWR_RST_HOLD_US_C * `SWR_CYC_PER_US)
`define SWR_RST_HOLD_CYC_D (`SWR_RST_HOLD_US_D * `SWR_CYC_PER_US)

// ****************************************************************
// Watchdog expiry options, typical values in microseconds
// ****************************************************************
`define SWR_WDOG_US_W      6300
`define SWR_WDOG_US_X      102000
`define SWR_WDOG_US_Y      1600000
`define SWR_WDOG_US_Z      25600000
`define SWR_WDOG_CYC_W     (`SWR_WDOG_US_W * `SWR_CYC_PER_US)
`define SWR_WDOG_CYC_X     (`SWR_WDOG_US_X * `SWR_CYC_PER_US)
`define SWR_WDOG_CYC_Y     (`SWR_WDOG_US_Y * `SWR_CYC_PER_US)
`define SWR_WDOG_CYC_Z     (`SWR_WDOG_US_Z * `SWR_CYC_PER_US)
`define SWR_SERVICE_NUM    7
`define SWR_SERVICE_DEN    8

// ****************************************************************
// Glitch filters and pullup one-shot
// ****************************************************************
`define SWR_MR_REJECT_NS   100
`define SWR_MR_FILT_CYC    (`SWR_MR_REJECT_NS / `SWR_CLK_PERIOD_NS + 1)
`define SWR_SUP_REJECT_NS  4000
`define SWR_SUP_FILT_CYC   (`SWR_SUP_REJECT_NS / `SWR_CLK_PERIOD_NS)
`define SWR_BOOST_NS       2000
`define SWR_BOOST_CYC      (`SWR_BOOST_NS / `SWR_CLK_PERIOD_NS)

// ****************************************************************
// Synchroniser bit positions
// ****************************************************************
`define SWR_SYNC_MR        0
`define SWR_SYNC_WD        1
`define SWR_SYNC_OPEN      2
`define SWR_SYNC_SUP       3
`define SWR_SYNC_LINE      4
`define SWR_SYNC_W         5

`endif

// ---- hdl/supervisor_watchdog_reset_pkg.sv ----
package supervisor_watchdog_reset_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    OUT_PP_HIGH,
    OUT_PP_LOW,
    OUT_OPEN_DRAIN,
    OUT_BIDIR
  } out_stage_t;

  typedef enum logic [1:0] {
    ST_ASSERT,
    ST_HOLD,
    ST_RUN
  } hold_state_t;

endpackage

// ---- hdl/supervisor_watchdog_reset.sv ----
// Overview of operation
// RL1 - Manual reset low asserts reset output
// RL2 - Hold reset full timeout after release
// RL3 - Reject short negative manual reset pulses
// RL4 - Switch bounce yields one clean reset
// RL5 - No watchdog edge within period: reset
// RL6 - Reset or watchdog edge clears counter
// RL7 - Short watchdog pulses still clear counter (pulses under one clock period can be missed)
// RL8 - Counter held zero during reset, restarts
// RL9 - Floating watchdog input disables watchdog
// RL10 - Floating input serviced at seven-eighths period
// RL11 - Filter brief small supply dips
// RL12 - Ignore short full-depth supply pulses
// RL13 - Bidirectional release accelerated for every cause
// RL14 - Passive pullup disconnected while asserting reset
// RL15 - Open-drain sinks only while reset asserted
// RL16 - Software toggles watchdog at distinct points
// RL17 - Keep watchdog input mostly low
// RL18 - Hold timeout after watchdog and brownout
// RL19 - Reset hold is build option
// RL20 - Watchdog period is build option
// RL21 - Synchronised watchdog input, either-edge clear
// RL22 - Output stage fixed build parameter
`timescale 1ns/10ps
`include "supervisor_watchdog_reset_params.svh"

module supervisor_watchdog_reset #(
  parameter int unsigned RESET_HOLD_CYCLES = `SWR_RST_HOLD_CYC_C, // RL19
  parameter int unsigned WDOG_CYCLES       = `SWR_WDOG_CYC_Y,     // RL20
  parameter supervisor_watchdog_reset_pkg::out_stage_t OUT_STAGE =
    supervisor_watchdog_reset_pkg::OUT_BIDIR                      // RL22
) (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic manual_reset_n_in,
  input  wire logic watchdog_toggle_in,
  input  wire logic watchdog_open_in,
  input  wire logic supply_low_in,
  input  wire logic reset_pin_in,
  output logic      reset_pin_out,
  output logic      reset_pin_oe_n_out,
  output logic      pullup_connect_out,
  output logic      reset_active_out
);

  // ****************************************************************
  // Constants
  // ****************************************************************
  localparam logic [31:0] HOLD_LAST    = 32'(RESET_HOLD_CYCLES - 1);
  localparam logic [31:0] WDOG_LAST    = 32'(WDOG_CYCLES - 1);
  // Divide first so long periods cannot overflow 32 bits
  localparam logic [31:0] SERVICE_LAST =
    32'((WDOG_CYCLES / `SWR_SERVICE_DEN) * `SWR_SERVICE_NUM - 1);
  localparam logic [7:0]  MR_FILT      = 8'(`SWR_MR_FILT_CYC);
  localparam logic [7:0]  SUP_FILT     = 8'(`SWR_SUP_FILT_CYC);
  localparam logic [7:0]  BOOST_LAST   = 8'(`SWR_BOOST_CYC - 1);
  localparam logic        IS_BIDIR     =
    (OUT_STAGE == supervisor_watchdog_reset_pkg::OUT_BIDIR);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [`SWR_SYNC_W-1:0] pin_raw;
  logic [`SWR_SYNC_W-1:0] sync1_r;
  logic [`SWR_SYNC_W-1:0] sync2_r;

  logic [7:0]             mr_cnt_r;
  logic [7:0]             mr_cnt_nxt;
  logic [7:0]             sup_cnt_r;
  logic [7:0]             sup_cnt_nxt;
  wire                    mr_low;
  wire                    sup_low;
  wire                    mr_cause;
  wire                    sup_cause;

  logic                   wd_prev_r;
  logic [31:0]            wd_cnt_r;
  logic [31:0]            wd_cnt_nxt;
  wire                    wd_edge;
  wire                    wd_open;
  wire                    wd_service;
  wire                    wd_clear;
  wire                    wd_fire;

  supervisor_watchdog_reset_pkg::hold_state_t state_r;
  supervisor_watchdog_reset_pkg::hold_state_t state_nxt;
  logic [31:0]            hold_cnt_r;
  logic [31:0]            hold_cnt_nxt;
  wire                    cause;
  wire                    active_nxt;
  logic                   active_r;

  logic                   seen_low_r;
  logic                   seen_low_nxt;
  logic                   boost_r;
  logic                   boost_nxt;
  logic [7:0]             boost_cnt_r;
  logic [7:0]             boost_cnt_nxt;
  wire                    line_high;
  wire                    boost_start;
  wire                    boost_done;

  logic                   pin_out_nxt;
  logic                   pin_oe_n_nxt;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  assign pin_raw[`SWR_SYNC_MR]   = manual_reset_n_in;
  assign pin_raw[`SWR_SYNC_WD]   = watchdog_toggle_in;
  assign pin_raw[`SWR_SYNC_OPEN] = watchdog_open_in;
  assign pin_raw[`SWR_SYNC_SUP]  = supply_low_in;
  assign pin_raw[`SWR_SYNC_LINE] = reset_pin_in;

  // Idle levels chosen so that reset is not re-caused at start-up
  generate
    for (genvar i = 0; i < `SWR_SYNC_W; i++) begin : g_sync
      localparam logic IDLE = (i != `SWR_SYNC_SUP) &&
                              (i != `SWR_SYNC_OPEN);
      always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          sync1_r[i] <= IDLE;
          sync2_r[i] <= IDLE;
        end else begin
          sync1_r[i] <= pin_raw[i];
          sync2_r[i] <= sync1_r[i];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Manual reset and supply filters
  // ****************************************************************
  assign mr_low    = !sync2_r[`SWR_SYNC_MR];
  assign sup_low   = sync2_r[`SWR_SYNC_SUP];
  // Low must last MR_FILT or SUP_FILT samples before it counts
  assign mr_cause  = (mr_cnt_r == MR_FILT);                 // RL1 RL3
  assign sup_cause = (sup_cnt_r == SUP_FILT);               // RL11 RL12

  assign mr_cnt_nxt  = !mr_low ? 8'h00 :
                       mr_cause ? mr_cnt_r : mr_cnt_r + 8'h01;
  assign sup_cnt_nxt = !sup_low ? 8'h00 :
                       sup_cause ? sup_cnt_r : sup_cnt_r + 8'h01;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mr_cnt_r  <= 8'h00;
      sup_cnt_r <= 8'h00;
    end else begin
      mr_cnt_r  <= mr_cnt_nxt;
      sup_cnt_r <= sup_cnt_nxt;
    end
  end

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  // Pulses under one clock period can slip between samples
  assign wd_edge    = sync2_r[`SWR_SYNC_WD] ^ wd_prev_r;   // RL21 RL7
  assign wd_open    = sync2_r[`SWR_SYNC_OPEN];              // RL9
  assign wd_service = wd_open && (wd_cnt_r == SERVICE_LAST); // RL10
  assign wd_clear   = active_r || wd_edge || wd_service;   // RL6 RL8
  assign wd_fire    = !wd_clear && (wd_cnt_r == WDOG_LAST); // RL5
  assign wd_cnt_nxt = (wd_clear || wd_fire) ? 32'h0000_0000 :
                      wd_cnt_r + 32'h0000_0001;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wd_prev_r <= 1'b1;
      wd_cnt_r  <= 32'h0000_0000;
    end else begin
      wd_prev_r <= sync2_r[`SWR_SYNC_WD];
      wd_cnt_r  <= wd_cnt_nxt;
    end
  end

  // ****************************************************************
  // Reset hold sequencer
  // ****************************************************************
  // Any live cause restarts the hold, so bounce gives one reset
  assign cause = mr_cause || sup_cause || wd_fire;          // RL4

  always_comb begin
    state_nxt    = state_r;
    hold_cnt_nxt = hold_cnt_r;
    case (state_r)
      supervisor_watchdog_reset_pkg::ST_ASSERT: begin
        hold_cnt_nxt = 32'h0000_0000;
        if (!cause) begin
          state_nxt = supervisor_watchdog_reset_pkg::ST_HOLD; // RL2 RL18
        end
      end
      supervisor_watchdog_reset_pkg::ST_HOLD: begin
        if (cause) begin
          state_nxt    = supervisor_watchdog_reset_pkg::ST_ASSERT;
          hold_cnt_nxt = 32'h0000_0000;
        end else if (hold_cnt_r >= HOLD_LAST) begin
          state_nxt    = supervisor_watchdog_reset_pkg::ST_RUN;
          hold_cnt_nxt = 32'h0000_0000;
        end else begin
          hold_cnt_nxt = hold_cnt_r + 32'h0000_0001;         // RL2
        end
      end
      supervisor_watchdog_reset_pkg::ST_RUN: begin
        if (cause) begin
          state_nxt = supervisor_watchdog_reset_pkg::ST_ASSERT;
        end
      end
      default: begin
        state_nxt    = supervisor_watchdog_reset_pkg::ST_ASSERT;
        hold_cnt_nxt = 32'h0000_0000;
      end
    endcase
  end

  assign active_nxt =
    (state_nxt != supervisor_watchdog_reset_pkg::ST_RUN);

  // Power-up starts a full hold as after a brownout
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r    <= supervisor_watchdog_reset_pkg::ST_HOLD;
      hold_cnt_r <= 32'h0000_0000;
      active_r   <= 1'b1;
    end else begin
      state_r    <= state_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      active_r   <= active_nxt;
    end
  end

  // ****************************************************************
  // Bidirectional pullup accelerator
  // ****************************************************************
  // Only pulls up once the line is already rising, so no fight
  // with a processor still holding the line low
  assign line_high   = sync2_r[`SWR_SYNC_LINE];
  assign boost_start = IS_BIDIR && seen_low_r && line_high &&
                       !active_r && !boost_r;                // RL13
  assign boost_done  = boost_r && (boost_cnt_r == BOOST_LAST);

  assign seen_low_nxt  = (IS_BIDIR && !line_high) ? 1'b1 :
                         boost_start ? 1'b0 : seen_low_r;
  assign boost_nxt     = boost_start ? 1'b1 :
                         (boost_done || active_r) ? 1'b0 : boost_r;
  assign boost_cnt_nxt = boost_r ? boost_cnt_r + 8'h01 : 8'h00;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      seen_low_r  <= 1'b0;
      boost_r     <= 1'b0;
      boost_cnt_r <= 8'h00;
    end else begin
      seen_low_r  <= seen_low_nxt;
      boost_r     <= boost_nxt;
      boost_cnt_r <= boost_cnt_nxt;
    end
  end

  // ****************************************************************
  // Output stage
  // ****************************************************************
  always_comb begin
    pin_out_nxt  = 1'b0;
    pin_oe_n_nxt = 1'b0;
    case (OUT_STAGE)
      supervisor_watchdog_reset_pkg::OUT_PP_HIGH: begin
        pin_out_nxt = active_nxt;                            // RL22
      end
      supervisor_watchdog_reset_pkg::OUT_PP_LOW: begin
        pin_out_nxt = !active_nxt;                           // RL22
      end
      supervisor_watchdog_reset_pkg::OUT_OPEN_DRAIN: begin
        pin_oe_n_nxt = !active_nxt;                          // RL15
      end
      supervisor_watchdog_reset_pkg::OUT_BIDIR: begin
        pin_out_nxt  = boost_nxt && !active_nxt;             // RL13
        pin_oe_n_nxt = !(active_nxt || boost_nxt);
      end
      default: begin
        pin_oe_n_nxt = !active_nxt;
      end
    endcase
  end

  // Pullup off while sinking saves supply current
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reset_pin_out      <= (OUT_STAGE ==
                             supervisor_watchdog_reset_pkg::OUT_PP_HIGH);
      reset_pin_oe_n_out <= 1'b0;
      pullup_connect_out <= 1'b0;
      reset_active_out   <= 1'b1;
    end else begin
      reset_pin_out      <= pin_out_nxt;
      reset_pin_oe_n_out <= pin_oe_n_nxt;
      pullup_connect_out <= IS_BIDIR && !active_nxt;         // RL14
      reset_active_out   <= active_nxt;
    end
  end

endmodule

// ---- tb/supervisor_watchdog_reset_chk.sv ----
`timescale 1ns/10ps
// ****************************************************************
// Reset supervisor checker
// ****************************************************************
module supervisor_watchdog_reset_chk #(
  parameter int unsigned RESET_HOLD_CYCLES = 50,
  parameter int unsigned WDOG_CYCLES       = 400
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic manual_reset_n_in,
  input wire logic watchdog_toggle_in,
  input wire logic watchdog_open_in,
  input wire logic supply_low_in,
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe_n_out,
  input wire logic pullup_connect_out,
  input wire logic reset_active_out
);
  int act_r;
  int idle_r;
  int quiet_r;
  int low_r;
  // Margins below absorb the input sync lag
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      act_r   <= 0;
      idle_r  <= 0;
      quiet_r <= 0;
      low_r   <= 0;
    end else begin
      act_r   <= reset_active_out ? act_r + 1 : 0;
      idle_r  <= (reset_active_out || watchdog_open_in ||
                  $changed(watchdog_toggle_in)) ? 0 : idle_r + 1;
      quiet_r <= (!manual_reset_n_in || supply_low_in) ? 0 : quiet_r + 1;
      low_r   <= supply_low_in ? low_r + 1 : 0;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  AST_MANUAL_LOW: assert property (
    !manual_reset_n_in [*8] |-> reset_active_out)
    else $error("manual reset low but reset inactive");
  AST_FULL_HOLD: assert property (
    $fell(reset_active_out) |-> act_r >= RESET_HOLD_CYCLES)
    else $error("reset released before hold ran out");
  AST_WDOG_FIRES: assert property (
    idle_r >= WDOG_CYCLES + 8 |-> reset_active_out)
    else $error("watchdog expired without reset");
  AST_NO_FALSE_RESET: assert property (
    $rose(reset_active_out) |-> quiet_r < 60 || idle_r + 8 >= WDOG_CYCLES)
    else $error("reset without a cause");
  AST_SUPPLY_LOW: assert property (
    low_r >= 46 |-> reset_active_out)
    else $error("long supply dip without reset");
  AST_PULLUP_OFF: assert property (
    $stable(reset_active_out) |-> pullup_connect_out != reset_active_out)
    else $error("pullup state wrong");
  AST_SINK_ACTIVE: assert property (
    reset_active_out && $past(reset_active_out) |->
      !reset_pin_oe_n_out && !reset_pin_out)
    else $error("line not sunk during reset");
  AST_BOOST_START: assert property (
    $rose(reset_pin_in) && !reset_active_out |->
      ##[2:6] (reset_pin_out && !reset_pin_oe_n_out))
    else $error("no accelerated release");
  AST_BOOST_LEN: assert property (
    $rose(reset_pin_out) |-> reset_pin_out [*8] ##[10:14] !reset_pin_out)
    else $error("boost length wrong");
  cover property ($fell(reset_active_out));
  cover property ($rose(reset_pin_out));
  cover property (watchdog_open_in [*8]);
endmodule

bind supervisor_watchdog_reset supervisor_watchdog_reset_chk #(
  .RESET_HOLD_CYCLES(RESET_HOLD_CYCLES),
  .WDOG_CYCLES(WDOG_CYCLES)
) u_supervisor_watchdog_reset_chk (
  .clk_in(clk_in), .arst_n_in(arst_n_in),
  .manual_reset_n_in(manual_reset_n_in),
  .watchdog_toggle_in(watchdog_toggle_in),
  .watchdog_open_in(watchdog_open_in), .supply_low_in(supply_low_in),
  .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
  .reset_pin_oe_n_out(reset_pin_oe_n_out),
  .pullup_connect_out(pullup_connect_out),
  .reset_active_out(reset_active_out)
);

// ---- tb/cpu_side_model.sv ----
`timescale 1ns/10ps
// ****************************************************************
// Processor side: reset line and watchdog output
// ****************************************************************
module cpu_side_model (
  input  wire logic drive_in,
  input  wire logic drive_oe_n_in,
  input  wire logic wd_level_in,
  input  wire logic float_in,
  input  wire logic pull_in,
  output logic      wd_out,
  output logic      open_out,
  output logic      line_out
);
  logic held_r;
  // Parked at inverse level so a stale value never passes
  always @(posedge float_in) held_r = ~wd_level_in;
  assign wd_out = float_in ? held_r : wd_level_in;
  assign open_out = float_in;
  // Pullup wins unless a party sinks the line
  assign line_out = ~((~drive_oe_n_in & ~drive_in) | pull_in);
endmodule

// ---- tb/supervisor_watchdog_reset_tb_top.sv ----
`timescale 1ns/10ps
// ****************************************************************
// Bench
// ****************************************************************
module supervisor_watchdog_reset_tb_top;
  localparam int HOLD = 50;
  localparam int WD   = 400;
  logic        clk_in     = 1'b0;
  logic        arst_n_in;
  logic        mr_n;
  logic        supply_low;
  logic        wd_lvl;
  logic        flt;
  logic        pull;
  logic        kick_on    = 1'b1;
  logic        wd, wd_open, line, pin, oe_n, pu, act;
  logic [31:0] seed       = 32'h00000052;
  logic        q[$];
  int          error_cnt  = 0;
  int          num_checks = 0;
  int          n;

  always #50 clk_in = ~clk_in;

  supervisor_watchdog_reset #(
    .RESET_HOLD_CYCLES(HOLD),
    .WDOG_CYCLES(WD),
    .OUT_STAGE(supervisor_watchdog_reset_pkg::OUT_BIDIR)
  ) u_supervisor_watchdog_reset (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .manual_reset_n_in(mr_n),
    .watchdog_toggle_in(wd), .watchdog_open_in(wd_open),
    .supply_low_in(supply_low), .reset_pin_in(line),
    .reset_pin_out(pin), .reset_pin_oe_n_out(oe_n),
    .pullup_connect_out(pu), .reset_active_out(act)
  );
  cpu_side_model u_cpu_side_model (
    .drive_in(pin), .drive_oe_n_in(oe_n), .wd_level_in(wd_lvl),
    .float_in(flt), .pull_in(pull), .wd_out(wd), .open_out(wd_open),
    .line_out(line)
  );

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic tick(int k = 1);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  task automatic check(logic seen, logic exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t ns: saw %b want %b", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wait_act(logic v, output int cyc);
    cyc = 0;
    while (act !== v) begin
      tick();
      cyc++;
      if (cyc > 2000) begin
        error_cnt++;
        $display("wrong value at %0t ns: timeout", $time);
        end_sim();
      end
    end
  endtask

  // Every edge of the reset flag must have been announced
  always @(act) begin
    if (arst_n_in === 1'b1) begin
      if (q.size() == 0) begin
        error_cnt++;
        $display("wrong value at %0t ns: unexpected reset edge", $time);
      end else begin
        check(act, q.pop_front());
      end
    end
  end

  // Brief high kicks; line mostly low to save current
  initial begin
    wd_lvl = 1'b0;
    forever begin
      tick(50 + int'(xs() % 251));
      if (kick_on) begin
        wd_lvl = 1'b1;
        tick();
        wd_lvl = 1'b0;
      end
    end
  end

  initial begin
    arst_n_in  = 1'b0;
    mr_n       = 1'b1;
    supply_low = 1'b0;
    flt        = 1'b0;
    pull       = 1'b0;
    tick(12);
    arst_n_in = 1'b1;
    q.push_back(1'b0);
    wait_act(1'b0, n);
    check(n >= HOLD && n <= HOLD + 8, 1'b1);
    mr_n = 1'b0;
    tick();
    mr_n = 1'b1;
    tick(30);
    q.push_back(1'b1);
    q.push_back(1'b0);
    for (int i = 0; i < 4; i++) begin
      mr_n = 1'b0;
      tick(3);
      mr_n = 1'b1;
      tick();
    end
    mr_n = 1'b0;
    tick(10);
    check(act, 1'b1);
    check(pu, 1'b0);
    check(oe_n, 1'b0);
    mr_n = 1'b1;
    wait_act(1'b0, n);
    check(n >= HOLD && n <= HOLD + 8, 1'b1);
    tick(6);
    check(pin & ~oe_n, 1'b1);
    kick_on = 1'b0;
    // Let a kick in flight end, so floating parks at the inverse
    tick(2);
    flt = 1'b1;
    tick(3 * WD);
    flt = 1'b0;
    repeat (2) begin
      q.push_back(1'b1);
      q.push_back(1'b0);
    end
    wait_act(1'b1, n);
    check(n >= WD - 2 && n <= WD + 8, 1'b1);
    wait_act(1'b0, n);
    check(n >= HOLD, 1'b1);
    wait_act(1'b1, n);
    check(n >= WD - 2 && n <= WD + 8, 1'b1);
    wait_act(1'b0, n);
    kick_on = 1'b1;
    for (int i = 0; i < 6; i++) begin
      supply_low = 1'b1;
      tick(2 + int'(xs() % 37));
      supply_low = 1'b0;
      tick(5);
    end
    q.push_back(1'b1);
    q.push_back(1'b0);
    supply_low = 1'b1;
    tick(60);
    check(act, 1'b1);
    supply_low = 1'b0;
    wait_act(1'b0, n);
    check(n >= HOLD, 1'b1);
    tick(30);
    pull = 1'b1;
    tick(8);
    check(pu, 1'b1);
    pull = 1'b0;
    tick(6);
    check(pin & ~oe_n, 1'b1);
    tick(30);
    check(oe_n, 1'b1);
    check(q.size() == 0, 1'b1);
    end_sim();
  end
endmodule
